// File: ivm_pkg.sv
package ivm_pkg;

  localparam int NODE_COUNT    = 50;
  localparam int HW_NODE_COUNT = 36;
  localparam int CHAN_COUNT    = 8;
  localparam int LEVEL_W       = 4;
  localparam int TRAP_W        = 7;
  localparam int IDX_W         = 6;
  localparam int CHAN_W        = 3;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 16;
  localparam int SEG_W         = 8;
  localparam int OFFS_W        = 16;
  localparam int COUNT_W       = 8;
  localparam int SPACING_W     = 3;

  // register offsets
  localparam logic [ADDR_W-1:0] NODE_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] SEG_ADDR  = 8'h40;
  localparam logic [ADDR_W-1:0] CFG_ADDR  = 8'h41;
  localparam logic [ADDR_W-1:0] CHAN_BASE = 8'h48;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h50;
  localparam logic [ADDR_W-1:0] MASK_ADDR = 8'h51;

  // field positions
  localparam int CFG_SPACING_LSB = 0;
  localparam int CHAN_CONT_BIT   = 8;
  localparam int NODE_CTRL_W     = 10;

  // reset values; spacing code 0 gives 4 bytes (two words) per vector
  localparam logic [SEG_W-1:0]     SEG_RESET        = 8'h00;
  localparam logic [SPACING_W-1:0] SPACING_RESET    = 3'h0;
  localparam int                   SPACING_BASE_SHL = 2;
  localparam logic [COUNT_W-1:0]   COUNT_RESET      = 8'h00;
  localparam logic [COUNT_W-1:0]   COUNT_ONE        = 8'h01;

  typedef struct packed {
    logic [CHAN_W-1:0]  chan;
    logic               transfer_sel;
    logic               node_request_flag;
    logic               enable;
    logic [LEVEL_W-1:0] level;
  } node_ctrl_t;

  typedef struct packed {
    logic               valid;
    logic [LEVEL_W-1:0] level;
    logic [TRAP_W-1:0]  trap;
    logic [SEG_W+OFFS_W-1:0] addr;
  } vector_req_t;

  typedef struct packed {
    logic               valid;
    logic [CHAN_W-1:0]  chan;
    logic [TRAP_W-1:0]  trap;
  } transfer_req_t;

  // fixed trap number of every node
  function automatic logic [TRAP_W-1:0] trap_of(input logic [IDX_W-1:0] idx);
    logic [TRAP_W-1:0] t;
    t = 7'h00;
    if (idx < 6'h10) begin
      t = 7'h10 + {1'b0, idx};
    end else if (idx < 6'h1D) begin
      t = 7'h20 + {1'b0, idx};
    end else if (idx < 6'h24) begin
      t = 7'h30 + {1'b0, idx};
    end else begin
      case (idx)
        6'h24:   t = 7'h54;
        6'h25:   t = 7'h55;
        6'h26:   t = 7'h56;
        6'h27:   t = 7'h57;
        6'h28:   t = 7'h59;
        6'h29:   t = 7'h5A;
        6'h2A:   t = 7'h5B;
        6'h2B:   t = 7'h5C;
        6'h2C:   t = 7'h5D;
        6'h2D:   t = 7'h40;
        6'h2E:   t = 7'h41;
        6'h2F:   t = 7'h4B;
        6'h30:   t = 7'h3F;
        default: t = 7'h58;
      endcase
    end
    return t;
  endfunction

endpackage

// File: node_arbiter.sv
`timescale 1ns/100ps
module node_arbiter
  import ivm_pkg::*;
#(
  parameter int N = NODE_COUNT
) (
  input  wire logic [N-1:0]         req_vec,
  input  wire logic [N*LEVEL_W-1:0] level_vec,
  output logic                      win_valid,
  output logic [IDX_W-1:0]          win_idx,
  output logic [LEVEL_W-1:0]        win_level
);

  // highest level wins; on a tie the lowest node index wins
  always_comb begin
    win_valid = 1'b0;
    win_idx   = '0;
    win_level = '0;
    for (int i = 0; i < N; i++) begin
      if (req_vec[i] && (!win_valid || level_vec[i*LEVEL_W +: LEVEL_W] > win_level)) begin
        win_valid = 1'b1;
        win_idx   = IDX_W'(i);
        win_level = level_vec[i*LEVEL_W +: LEVEL_W];
      end
    end
  end

endmodule // node_arbiter

// File: interrupt_vector_mapper.sv
`timescale 1ns/100ps
// Summary of operation
// - vector segment comes from segment register
// - vector spacing comes from configuration field
// - spacing resets to four bytes
// - default offset equals trap number times four
// - node selects vectored interrupt or transfer service
// - per-node request, enable and sixteen-level priority
// - only strictly higher priority preempts running service
// - software request flag acts like hardware source
// - transfer counts down unless continuous, zero gives vectored interrupt
module interrupt_vector_mapper
  import ivm_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  input  wire logic [ADDR_W-1:0]         reg_addr,
  input  wire logic [DATA_W-1:0]         reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [DATA_W-1:0]         reg_rdata,
  input  wire logic [HW_NODE_COUNT-1:0]  src_req,
  input  wire logic [LEVEL_W-1:0]        cpu_level,
  input  wire logic                      cpu_ack,
  input  wire logic                      xfer_ack,
  output vector_req_t                    vec_out,
  output transfer_req_t                  xfer_out,
  output logic                           irq
);

  node_ctrl_t                   node_r [NODE_COUNT];
  logic [SEG_W-1:0]             segment_r;
  logic [SPACING_W-1:0]         vector_spacing_field_r;
  logic [COUNT_W-1:0]           count_r [CHAN_COUNT];
  logic [CHAN_COUNT-1:0]        cont_r;
  logic [CHAN_COUNT-1:0]        status_r;
  logic [CHAN_COUNT-1:0]        mask_r;
  logic [DATA_W-1:0]            rdata_r;
  vector_req_t                  vec_r;
  transfer_req_t                xfer_r;
  logic [IDX_W-1:0]             idx_r;

  // address decode
  wire                          node_hit;
  wire                          chan_hit;
  wire [ADDR_W-1:0]             node_off;
  wire [ADDR_W-1:0]             chan_off;
  wire [IDX_W-1:0]              node_sel;
  wire [CHAN_W-1:0]             chan_sel;
  wire                          seg_we;
  wire                          cfg_we;
  wire                          stat_we;
  wire                          mask_we;

  assign node_off = reg_addr - NODE_BASE;
  assign chan_off = reg_addr - CHAN_BASE;
  assign node_hit = (reg_addr >= NODE_BASE) && (node_off < ADDR_W'(NODE_COUNT));
  assign chan_hit = (reg_addr >= CHAN_BASE) && (chan_off < ADDR_W'(CHAN_COUNT));
  assign node_sel = node_off[IDX_W-1:0];
  assign chan_sel = chan_off[CHAN_W-1:0];
  assign seg_we   = reg_wr && (reg_addr == SEG_ADDR);
  assign cfg_we   = reg_wr && (reg_addr == CFG_ADDR);
  assign stat_we  = reg_wr && (reg_addr == STAT_ADDR);
  assign mask_we  = reg_wr && (reg_addr == MASK_ADDR);

  // service in progress: acknowledge of the request currently presented
  wire                          vec_taken;
  wire                          xfer_taken;
  wire [CHAN_W-1:0]             taken_chan;
  wire                          taken_last;

  assign vec_taken  = cpu_ack && vec_r.valid;
  assign xfer_taken = xfer_ack && xfer_r.valid;
  assign taken_chan = xfer_r.chan;
  assign taken_last = !cont_r[taken_chan] && (count_r[taken_chan] == COUNT_ONE);

  // arbitration inputs
  logic [NODE_COUNT-1:0]         eligible;
  logic [NODE_COUNT*LEVEL_W-1:0] level_flat;
  logic [NODE_COUNT-1:0]         wants_xfer;
  wire                           win_valid;
  wire [IDX_W-1:0]               win_idx;
  wire [LEVEL_W-1:0]             win_level;

  genvar g;
  generate
    for (g = 0; g < NODE_COUNT; g++) begin : g_node
      wire        hw_set;
      wire        wr_hit;
      wire        sw_clr;
      wire        svc_clr;
      wire        req_nxt;
      node_ctrl_t wdata_c;

      assign wdata_c = node_ctrl_t'(reg_wdata[NODE_CTRL_W-1:0]);
      assign wr_hit  = reg_wr && node_hit && (node_sel == IDX_W'(g));
      if (g < HW_NODE_COUNT) begin : g_hw
        assign hw_set = src_req[g];
      end else begin : g_sw
        assign hw_set = 1'b0;
      end
      assign sw_clr  = wr_hit && !wdata_c.node_request_flag;
      // a transfer that empties the counter keeps the flag for the vectored interrupt
      assign svc_clr = (idx_r == IDX_W'(g)) && (vec_taken || (xfer_taken && !taken_last));
      // set wins over any clear in the same cycle
      assign req_nxt = hw_set || (wr_hit && wdata_c.node_request_flag)
                       || (node_r[g].node_request_flag && !sw_clr && !svc_clr);

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          node_r[g] <= '0;
        end else begin
          node_r[g].node_request_flag <= req_nxt;
          if (wr_hit) begin
            node_r[g].chan         <= wdata_c.chan;
            node_r[g].transfer_sel <= wdata_c.transfer_sel;
            node_r[g].enable       <= wdata_c.enable;
            node_r[g].level        <= wdata_c.level;
          end
        end
      end

      assign eligible[g] = node_r[g].node_request_flag && node_r[g].enable;
      assign level_flat[g*LEVEL_W +: LEVEL_W] = node_r[g].level;
      // transfer service while its channel still has work, otherwise vectored
      assign wants_xfer[g] = node_r[g].transfer_sel
                             && (cont_r[node_r[g].chan] || (count_r[node_r[g].chan] != COUNT_RESET));
    end
  endgenerate

  node_arbiter #(
    .N         (NODE_COUNT)
  ) u_arbiter (
    .req_vec   (eligible),
    .level_vec (level_flat),
    .win_valid (win_valid),
    .win_idx   (win_idx),
    .win_level (win_level)
  );

  // vector address forming
  wire [TRAP_W-1:0]             win_trap;
  wire [OFFS_W-1:0]             win_offset;
  wire                          preempts;
  wire                          win_is_xfer;
  wire                          present_ok;

  assign win_trap    = trap_of(win_idx);
  // default spacing: offset = trap * 4, e.g. trap 10h -> 0040h
  // shift amount is one bit wider than the code so code 7 reaches a shift of nine instead of wrapping
  assign win_offset  = OFFS_W'({{(OFFS_W-TRAP_W){1'b0}}, win_trap}
                       << ({1'b0, vector_spacing_field_r} + (SPACING_W+1)'(SPACING_BASE_SHL)));
  assign preempts    = win_valid && (win_level > cpu_level);
  assign win_is_xfer = wants_xfer[win_idx];
  // the output is withdrawn for one cycle after any acknowledge so a stale request is never seen twice
  assign present_ok  = preempts && !cpu_ack && !xfer_ack;

  vector_req_t                  vec_nxt;
  transfer_req_t                xfer_nxt;

  assign vec_nxt.valid   = present_ok && !win_is_xfer;
  assign vec_nxt.level   = win_level;
  assign vec_nxt.trap    = win_trap;
  assign vec_nxt.addr    = {segment_r, win_offset};
  assign xfer_nxt.valid  = present_ok && win_is_xfer;
  assign xfer_nxt.chan   = node_r[win_idx].chan;
  assign xfer_nxt.trap   = win_trap;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      vec_r  <= '0;
      xfer_r <= '0;
      idx_r  <= '0;
    end else begin
      vec_r  <= vec_nxt;
      xfer_r <= xfer_nxt;
      idx_r  <= win_idx;
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      segment_r              <= SEG_RESET;
      vector_spacing_field_r <= SPACING_RESET;
      mask_r                 <= '0;
    end else begin
      if (seg_we) begin
        segment_r <= reg_wdata[SEG_W-1:0];
      end
      if (cfg_we) begin
        vector_spacing_field_r <= reg_wdata[CFG_SPACING_LSB +: SPACING_W];
      end
      if (mask_we) begin
        mask_r <= reg_wdata[CHAN_COUNT-1:0];
      end
    end
  end

  // transfer channels
  generate
    for (g = 0; g < CHAN_COUNT; g++) begin : g_chan
      wire wr_hit;
      wire served;
      wire done_evt;

      assign wr_hit   = reg_wr && chan_hit && (chan_sel == CHAN_W'(g));
      assign served   = xfer_taken && (taken_chan == CHAN_W'(g));
      assign done_evt = served && taken_last;

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          count_r[g] <= COUNT_RESET;
          cont_r[g]  <= 1'b0;
          status_r[g] <= 1'b0;
        end else begin
          if (wr_hit) begin
            count_r[g] <= reg_wdata[COUNT_W-1:0];
            cont_r[g]  <= reg_wdata[CHAN_CONT_BIT];
          end else if (served && !cont_r[g]) begin
            count_r[g] <= count_r[g] - COUNT_ONE;
          end
          // event set wins over a write-one clear
          status_r[g] <= done_evt || (status_r[g] && !(stat_we && reg_wdata[g]));
        end
      end
    end
  endgenerate

  assign irq = |(status_r & mask_r);

  // read path, answer stands one cycle after the strobe only
  logic [DATA_W-1:0] read_mux;

  always_comb begin
    read_mux = '0;
    if (node_hit) begin
      read_mux = DATA_W'(node_r[node_sel]);
    end else if (chan_hit) begin
      read_mux = DATA_W'({cont_r[chan_sel], count_r[chan_sel]});
    end else if (reg_addr == SEG_ADDR) begin
      read_mux = DATA_W'(segment_r);
    end else if (reg_addr == CFG_ADDR) begin
      read_mux = DATA_W'(vector_spacing_field_r);
    end else if (reg_addr == STAT_ADDR) begin
      read_mux = DATA_W'(status_r);
    end else if (reg_addr == MASK_ADDR) begin
      read_mux = DATA_W'(mask_r);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? read_mux : '0;
    end
  end

  assign reg_rdata = rdata_r;
  assign vec_out   = vec_r;
  assign xfer_out  = xfer_r;

endmodule // interrupt_vector_mapper

// File: ivm_asserts.sv
`timescale 1ns/100ps
module ivm_asserts
  import ivm_pkg::*;
(
  input wire logic [0:0]               sys_clk,
  input wire logic                     resetn,
  input wire logic [ADDR_W-1:0]        reg_addr,
  input wire logic [DATA_W-1:0]        reg_wdata,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [DATA_W-1:0]        reg_rdata,
  input wire logic [HW_NODE_COUNT-1:0] src_req,
  input wire logic [LEVEL_W-1:0]       cpu_level,
  input wire logic                     cpu_ack,
  input wire logic                     xfer_ack,
  input wire vector_req_t              vec_out,
  input wire transfer_req_t            xfer_out,
  input wire logic                     irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // offset must match one of the eight spacings; the checker cannot see the code itself
  function automatic logic fits(input vector_req_t v);
    logic ok;
    ok = 1'b0;
    for (int s = 2; s < 10; s++)
      if (v.addr[15:0] == 16'({9'h000, v.trap} << s)) ok = 1'b1;
    return ok;
  endfunction
  wire logic spacing_ok;
  assign spacing_ok = fits(vec_out);
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_seg_narrow: assert property (reg_rd && reg_addr == SEG_ADDR |=> reg_rdata[15:8] == 8'h00)
    else $error("segment read has upper bits set");
  a_prio_strict: assert property (vec_out.valid |-> vec_out.level > $past(cpu_level))
    else $error("vector not above running level");
  a_ack_drop: assert property (cpu_ack && vec_out.valid |=> !vec_out.valid && !xfer_out.valid)
    else $error("vector kept after accept");
  a_xack_drop: assert property (xfer_ack && xfer_out.valid |=> !xfer_out.valid && !vec_out.valid)
    else $error("transfer kept after accept");
  a_one_service: assert property (!(vec_out.valid && xfer_out.valid))
    else $error("vector and transfer at once");
  a_irq_cause: assert property ($rose(irq) |-> $past(xfer_ack) || $past(reg_wr))
    else $error("irq rose without cause");
  a_spacing_fit: assert property (vec_out.valid |-> spacing_ok && vec_out.addr[1:0] == 2'b00)
    else $error("vector offset off spacing grid");
  a_trap_span: assert property (vec_out.valid |-> vec_out.trap inside
    {[7'h10:7'h1F], [7'h30:7'h3C], [7'h3F:7'h41], 7'h4B, [7'h4D:7'h5D]})
    else $error("trap number outside node table");
  c_vec: cover property (vec_out.valid && cpu_ack);
  c_xfer: cover property (xfer_out.valid && xfer_ack);
  c_irq: cover property ($rose(irq));
endmodule // ivm_asserts

// File: cpu_model.sv
`timescale 1ns/100ps
module cpu_model
  import ivm_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          resetn,
  input wire vector_req_t   vec_out,
  input wire transfer_req_t xfer_out,
  input wire logic [3:0]    lat,
  output logic              cpu_ack,
  output logic              xfer_ack,
  output logic [7:0]        nv,
  output logic [7:0]        nx,
  output vector_req_t       seen_v,
  output transfer_req_t     seen_x
);
  logic [3:0] wait_r;
  // ack is held one cycle only; a late ack may find the offer withdrawn, which the block ignores
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_ack  <= 1'b0;
      xfer_ack <= 1'b0;
      wait_r   <= 4'h0;
      nv       <= 8'h00;
      nx       <= 8'h00;
      seen_v   <= '0;
      seen_x   <= '0;
    end else if (cpu_ack || xfer_ack) begin
      cpu_ack  <= 1'b0;
      xfer_ack <= 1'b0;
      wait_r   <= 4'h0;
      if (cpu_ack && vec_out.valid) begin
        nv     <= nv + 8'h01;
        seen_v <= vec_out;
      end
      if (xfer_ack && xfer_out.valid) begin
        nx     <= nx + 8'h01;
        seen_x <= xfer_out;
      end
    end else if (vec_out.valid || xfer_out.valid) begin
      wait_r   <= wait_r + 4'h1;
      cpu_ack  <= (wait_r >= lat) && vec_out.valid;
      xfer_ack <= (wait_r >= lat) && xfer_out.valid;
    end else begin
      wait_r <= 4'h0;
    end
  end
endmodule // cpu_model

// File: interrupt_vector_mapper_test.sv
`timescale 1ns/100ps
module interrupt_vector_mapper_test import ivm_pkg::*;;
  logic                     sys_clk   = 1'b0;
  logic                     resetn    = 1'b0;
  logic [ADDR_W-1:0]        reg_addr  = 8'h00;
  logic [DATA_W-1:0]        reg_wdata = 16'h0000;
  logic                     reg_wr    = 1'b0;
  logic                     reg_rd    = 1'b0;
  logic [HW_NODE_COUNT-1:0] src_req   = '0;
  logic [LEVEL_W-1:0]       cpu_level = 4'h0;
  logic [3:0]               lat       = 4'h0;
  logic [DATA_W-1:0]        reg_rdata;
  logic                     cpu_ack, xfer_ack, irq;
  vector_req_t              vec_out, seen_v;
  transfer_req_t            xfer_out, seen_x;
  logic [7:0]               nv, nx, ev, ex;
  int                       errors = 0, n_checks = 0, cyc = 0;
  int                       nidx [13] = '{0, 15, 16, 28, 29, 32, 33, 35, 36, 40, 45, 48, 49};
  logic [6:0]               ntrp [13] = '{7'h10, 7'h1F, 7'h30, 7'h3C, 7'h4D, 7'h50, 7'h51, 7'h53, 7'h54,
                                          7'h59, 7'h40, 7'h3F, 7'h58};
  interrupt_vector_mapper dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req), .cpu_level(cpu_level),
    .cpu_ack(cpu_ack), .xfer_ack(xfer_ack), .vec_out(vec_out), .xfer_out(xfer_out), .irq(irq));
  cpu_model cpu (.sys_clk(sys_clk), .resetn(resetn), .vec_out(vec_out), .xfer_out(xfer_out), .lat(lat),
    .cpu_ack(cpu_ack), .xfer_ack(xfer_ack), .nv(nv), .nx(nx), .seen_v(seen_v), .seen_x(seen_x));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic irqc(input logic e);
    @(negedge sys_clk);
    chk({23'h0, irq}, {23'h0, e});
  endtask
  // hardware nodes get a source pulse, unassigned ones only the software flag
  task automatic trig(input int i, input logic [15:0] c);
    if (i < HW_NODE_COUNT) begin
      wr(8'(i), c);
      @(posedge sys_clk);
      src_req <= 36'h1 << i;
      @(posedge sys_clk);
      src_req <= '0;
    end else begin
      wr(8'(i), c | 16'h0020);
    end
  endtask
  task automatic waitg(input logic x);
    for (int k = 0; k < 60 && (x ? nx === ex : nv === ev); k++) @(negedge sys_clk);
    if (x) ex++;
    else ev++;
    chk({16'h0, x ? nx : nv}, {16'h0, x ? ex : ev});
  endtask
  task automatic vchk(input logic [6:0] t, input logic [23:0] a);
    waitg(1'b0);
    chk({17'h0, seen_v.trap}, {17'h0, t});
    chk(seen_v.addr, a);
  endtask
  initial begin
    ev = 8'h00;
    ex = 8'h00;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc(SEG_ADDR, 16'h0000);
    rdc(CFG_ADDR, 16'h0000);
    rdc(NODE_BASE, 16'h0000);
    rdc(CHAN_BASE, 16'h0000);
    rdc(STAT_ADDR, 16'h0000);
    rdc(MASK_ADDR, 16'h0000);
    wr(8'h3F, 16'hFFFF);
    rdc(8'h3F, 16'h0000);
    wr(SEG_ADDR, 16'hFFFF);
    rdc(SEG_ADDR, 16'h00FF);
    wr(SEG_ADDR, 16'h00A5);
    $display("register test done");
    for (int i = 0; i < 13; i++) begin
      trig(nidx[i], 16'h0015);
      vchk(ntrp[i], {8'hA5, 7'h00, ntrp[i], 2'b00});
    end
    rdc(NODE_BASE, 16'h0015);
    wr(CFG_ADDR, 16'h0001);
    trig(0, 16'h0015);
    vchk(7'h10, 24'hA50080);
    wr(CFG_ADDR, 16'h0007);
    trig(1, 16'h0015);
    vchk(7'h11, 24'hA52200);
    wr(CFG_ADDR, 16'h0000);
    $display("vector table test done");
    cpu_level <= 4'h5;
    trig(2, 16'h0015);
    repeat (10) @(negedge sys_clk);
    chk({16'h0, nv}, {16'h0, ev});
    wr(8'h02, 16'h0036);
    vchk(7'h12, 24'hA50048);
    cpu_level <= 4'hF;
    lat       <= 4'h3;
    wr(8'h03, 16'h0037);
    wr(8'h04, 16'h0038);
    cpu_level <= 4'h0;
    vchk(7'h14, 24'hA50050);
    chk({20'h0, seen_v.level}, 24'h000008);
    vchk(7'h13, 24'hA5004C);
    $display("priority test done");
    lat <= 4'h0;
    wr(CHAN_BASE + 8'h02, 16'h0002);
    wr(MASK_ADDR, 16'h0004);
    trig(2, 16'h0155);
    waitg(1'b1);
    chk({21'h0, seen_x.chan}, 24'h000002);
    chk({17'h0, seen_x.trap}, 24'h000012);
    rdc(CHAN_BASE + 8'h02, 16'h0001);
    irqc(1'b0);
    trig(2, 16'h0155);
    waitg(1'b1);
    rdc(CHAN_BASE + 8'h02, 16'h0000);
    rdc(STAT_ADDR, 16'h0004);
    vchk(7'h12, 24'hA50048);
    irqc(1'b1);
    wr(MASK_ADDR, 16'h0000);
    irqc(1'b0);
    wr(MASK_ADDR, 16'h0004);
    irqc(1'b1);
    wr(STAT_ADDR, 16'h0004);
    irqc(1'b0);
    rdc(STAT_ADDR, 16'h0000);
    wr(CHAN_BASE + 8'h03, 16'h0101);
    trig(3, 16'h01D5);
    waitg(1'b1);
    chk({21'h0, seen_x.chan}, 24'h000003);
    rdc(CHAN_BASE + 8'h03, 16'h0101);
    $display("transfer test done");
    give_verdict();
  end
endmodule // interrupt_vector_mapper_test
bind interrupt_vector_mapper ivm_asserts u_chk (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req),
  .cpu_level(cpu_level), .cpu_ack(cpu_ack), .xfer_ack(xfer_ack), .vec_out(vec_out), .xfer_out(xfer_out), .irq(irq));
